// [hw/cmb_pkg.sv]
package cmb_pkg;
    // data space
    localparam int ADDR_W = 16;
    localparam logic [15:0] NV_BASE = 16'h4000;
    localparam logic [15:0] SP_RESET = 16'h0fff;
    localparam logic [15:0] ONE = 16'h0001;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    // cycles after the first for a program memory load
    localparam logic [1:0] PM_WAIT = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP, OP_BREAK, OP_SLEEP, OP_WDOG,
        OP_MOV, OP_LDI, OP_LDDIR, OP_LD, OP_STS, OP_STI,
        OP_PML, OP_PML_R0, OP_IN, OP_OUT, OP_PUSH, OP_POP,
        OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP,
        OP_SBI, OP_CBI, OP_BST, OP_BITLD, OP_BSET, OP_BCLR
    } cmb_op_t;

    typedef enum logic [1:0] {
        AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISP
    } cmb_mode_t;
endpackage : cmb_pkg

// [hw/cmb_exec.sv]
`timescale 1ns/10ps
// Operation
// RULE1: direct load takes three cycles, flags kept
// RULE2: post-increment store writes then bumps pointer
// RULE3: pre-decrement store drops pointer then writes
// RULE4: push one cycle, pop two, flags kept
// RULE5: bit load copies transfer flag into bit
// RULE6: break, nop, sleep, watchdog restart: one cycle
// RULE7: listed counts hold for internal RAM only
// RULE8: nonvolatile access adds at least one cycle
// RULE9: stall on nonvolatile access until granted
// RULE10: program load via Z in three cycles
// RULE11: shifts and flag ops one cycle, named flags
module cmb_exec
    import cmb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // decoded operation
    input wire logic op_valid,
    input wire cmb_op_t op_code,
    input wire cmb_mode_t op_mode,
    input wire logic [4:0] op_dest,
    input wire logic [2:0] op_bit,
    input wire logic [15:0] op_addr,
    input wire logic [7:0] op_src_value,
    input wire logic [7:0] op_dest_value,
    input wire logic [15:0] ptr_value,
    input wire logic [7:0] io_rdata,
    output logic ready,
    output logic op_done,
    // register file write back
    output logic rf_we,
    output logic [4:0] rf_waddr,
    output logic [7:0] rf_wdata,
    output logic ptr_we,
    output logic [15:0] ptr_wdata,
    output logic [7:0] status_flags_register,
    output logic [15:0] stack_pointer,
    // data bus
    output logic bus_req,
    output logic bus_we,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_ack,
    // i/o space
    output logic io_we,
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata,
    // program memory
    output logic pm_req,
    output logic [15:0] pm_addr,
    input wire logic [7:0] pm_rdata,
    // side effects for debug, power and watchdog units
    output logic break_pulse,
    output logic sleep_pulse,
    output logic watchdog_restart
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_LOAD, S_STORE, S_PM} cmb_state_t;

    cmb_state_t state, next_state;
    logic [1:0] cnt, next_cnt;
    logic acc_nv, next_acc_nv;
    logic acc_extra, next_acc_extra;
    logic sav_store, next_sav_store;
    logic [4:0] sav_dest, next_sav_dest;
    logic [15:0] sav_addr, next_sav_addr;
    logic [7:0] sav_data, next_sav_data;
    logic next_ready, next_op_done, next_rf_we, next_ptr_we, next_bus_req, next_bus_we;
    logic next_io_we, next_pm_req, next_break_pulse, next_sleep_pulse, next_watchdog_restart;
    logic [4:0] next_rf_waddr;
    logic [7:0] next_rf_wdata, next_bus_wdata, next_io_wdata, next_status_flags_register;
    logic [15:0] next_ptr_wdata, next_bus_addr, next_pm_addr, next_stack_pointer;
    logic [5:0] next_io_addr;
    logic issue_load, issue_store;
    logic [15:0] issue_addr, ea;
    logic [7:0] issue_data, sh_res, bit_mask;
    logic sh_c, finish;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_acc_nv = acc_nv;
        next_acc_extra = acc_extra;
        next_sav_store = sav_store;
        next_sav_dest = sav_dest;
        next_sav_addr = sav_addr;
        next_sav_data = sav_data;
        next_op_done = 1'b0;
        next_rf_we = 1'b0;
        next_rf_waddr = rf_waddr;
        next_rf_wdata = rf_wdata;
        next_ptr_we = 1'b0;
        next_ptr_wdata = ptr_wdata;
        next_status_flags_register = status_flags_register;
        next_stack_pointer = stack_pointer;
        next_bus_req = 1'b0;
        next_bus_we = bus_we;
        next_bus_addr = bus_addr;
        next_bus_wdata = bus_wdata;
        next_io_we = 1'b0;
        next_io_addr = io_addr;
        next_io_wdata = io_wdata;
        next_pm_req = 1'b0;
        next_pm_addr = pm_addr;
        next_break_pulse = 1'b0;
        next_sleep_pulse = 1'b0;
        next_watchdog_restart = 1'b0;
        issue_load = 1'b0;
        issue_store = 1'b0;
        issue_addr = sav_addr;
        issue_data = sav_data;
        sh_res = 8'h00;
        sh_c = 1'b0;
        finish = 1'b0;
        bit_mask = 8'h01 << op_bit;
        case (op_mode)
            AM_PREDEC: ea = ptr_value - ONE;
            AM_DISP: ea = ptr_value + {10'h000, op_addr[5:0]};
            default: ea = ptr_value;
        endcase
        case (state)
            S_IDLE:
            begin
                if (op_valid)
                begin
                    next_op_done = 1'b1;
                    next_rf_waddr = op_dest;
                    next_sav_dest = op_dest;
                    next_ptr_wdata = (op_mode == AM_PREDEC) ? ea : ptr_value + ONE;
                    next_ptr_we = (op_mode == AM_POSTINC || op_mode == AM_PREDEC)
                        && (op_code == OP_LD || op_code == OP_STI || op_code == OP_PML); // see RULE2 RULE3
                    case (op_code)
                        OP_BREAK: next_break_pulse = 1'b1; // see RULE6
                        OP_SLEEP: next_sleep_pulse = 1'b1; // see RULE6
                        OP_WDOG: next_watchdog_restart = 1'b1; // see RULE6
                        OP_MOV:
                        begin
                            next_rf_we = 1'b1;
                            next_rf_wdata = op_src_value;
                        end
                        OP_LDI:
                        begin
                            next_rf_we = 1'b1;
                            next_rf_wdata = op_addr[7:0];
                        end
                        OP_LDDIR, OP_STS:
                        begin
                            // one cycle spent taking the address word
                            next_op_done = 1'b0;
                            next_state = S_ADDR; // see RULE1
                            next_sav_store = (op_code == OP_STS);
                            next_sav_addr = op_addr;
                            next_sav_data = op_src_value;
                        end
                        OP_LD:
                        begin
                            issue_load = 1'b1;
                            issue_addr = ea;
                        end
                        OP_STI:
                        begin
                            issue_store = 1'b1; // see RULE2 RULE3
                            issue_addr = ea;
                            issue_data = op_src_value;
                        end
                        OP_PML, OP_PML_R0:
                        begin
                            next_op_done = 1'b0;
                            next_state = S_PM; // see RULE10
                            next_cnt = PM_WAIT;
                            next_pm_req = 1'b1;
                            next_pm_addr = ptr_value;
                            if (op_code == OP_PML_R0)
                            begin
                                next_sav_dest = 5'h00;
                            end
                        end
                        OP_IN:
                        begin
                            next_rf_we = 1'b1;
                            next_rf_wdata = io_rdata;
                        end
                        OP_OUT, OP_SBI, OP_CBI:
                        begin
                            next_io_we = 1'b1; // see RULE11
                            next_io_addr = op_addr[5:0];
                            next_io_wdata = (op_code == OP_OUT) ? op_src_value :
                                (op_code == OP_SBI) ? (io_rdata | bit_mask) : (io_rdata & ~bit_mask);
                        end
                        OP_PUSH:
                        begin
                            issue_store = 1'b1; // see RULE4
                            issue_addr = stack_pointer;
                            issue_data = op_src_value;
                            next_stack_pointer = stack_pointer - ONE;
                        end
                        OP_POP:
                        begin
                            issue_load = 1'b1; // see RULE4
                            issue_addr = stack_pointer + ONE;
                            next_stack_pointer = stack_pointer + ONE;
                        end
                        OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR:
                        begin
                            case (op_code)
                                OP_LSL: sh_res = {op_dest_value[6:0], 1'b0};
                                OP_ROL: sh_res = {op_dest_value[6:0], status_flags_register[FLAG_C]};
                                OP_LSR: sh_res = {1'b0, op_dest_value[7:1]};
                                OP_ROR: sh_res = {status_flags_register[FLAG_C], op_dest_value[7:1]};
                                default: sh_res = {op_dest_value[7], op_dest_value[7:1]};
                            endcase
                            sh_c = (op_code == OP_LSL || op_code == OP_ROL) ?
                                op_dest_value[7] : op_dest_value[0];
                            next_rf_we = 1'b1; // see RULE11
                            next_rf_wdata = sh_res;
                            next_status_flags_register[FLAG_C] = sh_c;
                            next_status_flags_register[FLAG_Z] = (sh_res == 8'h00);
                            next_status_flags_register[FLAG_N] = sh_res[7];
                            next_status_flags_register[FLAG_V] = sh_res[7] ^ sh_c;
                            next_status_flags_register[FLAG_S] = sh_c;
                            if (op_code == OP_LSL || op_code == OP_ROL)
                            begin
                                next_status_flags_register[FLAG_H] = op_dest_value[3];
                            end
                        end
                        OP_SWAP:
                        begin
                            next_rf_we = 1'b1; // see RULE11
                            next_rf_wdata = {op_dest_value[3:0], op_dest_value[7:4]};
                        end
                        OP_BST: next_status_flags_register[FLAG_T] = op_src_value[op_bit];
                        OP_BITLD:
                        begin
                            next_rf_we = 1'b1; // see RULE5
                            next_rf_wdata = status_flags_register[FLAG_T] ?
                                (op_dest_value | bit_mask) : (op_dest_value & ~bit_mask);
                        end
                        OP_BSET: next_status_flags_register[op_bit] = 1'b1; // see RULE11
                        OP_BCLR: next_status_flags_register[op_bit] = 1'b0; // see RULE11
                        default: next_op_done = 1'b1; // see RULE6
                    endcase
                end
            end
            S_ADDR:
            begin
                issue_load = !sav_store; // see RULE1
                issue_store = sav_store;
            end
            S_LOAD:
            begin
                // the first nonvolatile cycle never finishes, giving the extra cycle
                next_acc_extra = 1'b1;
                finish = !acc_nv || (acc_extra && bus_ack); // see RULE7 RULE8 RULE9
                next_bus_req = !finish;
                if (finish)
                begin
                    next_rf_we = 1'b1;
                    next_rf_waddr = sav_dest;
                    next_rf_wdata = bus_rdata;
                    next_op_done = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_STORE:
            begin
                next_bus_req = !bus_ack; // see RULE9
                if (bus_ack)
                begin
                    next_op_done = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_PM:
            begin
                next_pm_req = (cnt != 2'h1);
                next_cnt = cnt - 2'h1;
                if (cnt == 2'h1)
                begin
                    next_rf_we = 1'b1; // see RULE10
                    next_rf_waddr = sav_dest;
                    next_rf_wdata = pm_rdata;
                    next_op_done = 1'b1;
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
        if (issue_load || issue_store)
        begin
            next_bus_req = 1'b1;
            next_bus_we = issue_store;
            next_bus_addr = issue_addr;
            next_bus_wdata = issue_data;
            next_acc_nv = (issue_addr >= NV_BASE); // see RULE7
            // a store pays its extra cycle by entering the wait state
            next_acc_extra = issue_store;
            next_op_done = 1'b0;
            if (issue_load)
            begin
                next_state = S_LOAD;
            end
            else if (issue_addr >= NV_BASE)
            begin
                next_state = S_STORE; // see RULE8
            end
            else
            begin
                next_state = S_IDLE;
                next_op_done = 1'b1;
            end
        end
        next_ready = (next_state == S_IDLE);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state <= S_IDLE;
            cnt <= 2'h0;
            acc_nv <= 1'b0;
            acc_extra <= 1'b0;
            sav_store <= 1'b0;
            sav_dest <= 5'h00;
            sav_addr <= 16'h0000;
            sav_data <= 8'h00;
            ready <= 1'b1;
            op_done <= 1'b0;
            rf_we <= 1'b0;
            rf_waddr <= 5'h00;
            rf_wdata <= 8'h00;
            ptr_we <= 1'b0;
            ptr_wdata <= 16'h0000;
            status_flags_register <= FLAGS_RESET;
            stack_pointer <= SP_RESET;
            bus_req <= 1'b0;
            bus_we <= 1'b0;
            bus_addr <= 16'h0000;
            bus_wdata <= 8'h00;
            io_we <= 1'b0;
            io_addr <= 6'h00;
            io_wdata <= 8'h00;
            pm_req <= 1'b0;
            pm_addr <= 16'h0000;
            break_pulse <= 1'b0;
            sleep_pulse <= 1'b0;
            watchdog_restart <= 1'b0;
        end
        else if (clock_enable)
        begin
            state <= next_state;
            cnt <= next_cnt;
            acc_nv <= next_acc_nv;
            acc_extra <= next_acc_extra;
            sav_store <= next_sav_store;
            sav_dest <= next_sav_dest;
            sav_addr <= next_sav_addr;
            sav_data <= next_sav_data;
            ready <= next_ready;
            op_done <= next_op_done;
            rf_we <= next_rf_we;
            rf_waddr <= next_rf_waddr;
            rf_wdata <= next_rf_wdata;
            ptr_we <= next_ptr_we;
            ptr_wdata <= next_ptr_wdata;
            status_flags_register <= next_status_flags_register;
            stack_pointer <= next_stack_pointer;
            bus_req <= next_bus_req;
            bus_we <= next_bus_we;
            bus_addr <= next_bus_addr;
            bus_wdata <= next_bus_wdata;
            io_we <= next_io_we;
            io_addr <= next_io_addr;
            io_wdata <= next_io_wdata;
            pm_req <= next_pm_req;
            pm_addr <= next_pm_addr;
            break_pulse <= next_break_pulse;
            sleep_pulse <= next_sleep_pulse;
            watchdog_restart <= next_watchdog_restart;
        end
    end

    // checks assume clock_enable stays high
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset || !clock_enable);
    logic acc;
    assign acc = op_valid && ready;
    sequence s_busy2;
        (!ready && $stable(status_flags_register)) [*2];
    endsequence
    sequence s_end_write;
        ready && op_done && rf_we;
    endsequence

    AST_LDIR_RAM: assert property (acc && op_code == OP_LDDIR && op_addr < NV_BASE // see RULE1
        |=> s_busy2 ##1 (s_end_write and $stable(status_flags_register)))
        else $error("direct load count wrong");
    AST_STI_POSTINC: assert property (acc && op_code == OP_STI // see RULE2
        && op_mode == AM_POSTINC && ptr_value < NV_BASE |=> ready && op_done && bus_req && bus_we
        && bus_addr == $past(ptr_value) && ptr_we && ptr_wdata == bus_addr + ONE)
        else $error("post-increment store wrong");
    AST_STI_PREDEC: assert property (acc && op_code == OP_STI && op_mode == AM_PREDEC // see RULE3
        && ptr_value > 16'h0000 && ptr_value <= NV_BASE |=> ready && bus_req && bus_we
        && bus_addr == $past(ptr_value) - ONE && ptr_we && ptr_wdata == bus_addr)
        else $error("pre-decrement store wrong");
    AST_PUSH: assert property (acc && op_code == OP_PUSH && stack_pointer < NV_BASE // see RULE4
        |=> ready && bus_we && bus_addr == $past(stack_pointer)
        && stack_pointer == bus_addr - ONE && $stable(status_flags_register))
        else $error("push wrong");
    AST_POP: assert property (acc && op_code == OP_POP // see RULE4
        && stack_pointer < NV_BASE - ONE
        |=> !ready ##1 (s_end_write and rf_wdata == $past(bus_rdata)))
        else $error("pop wrong");
    AST_BITLD: assert property (acc && op_code == OP_BITLD |=> ready && rf_we // see RULE5
        && rf_wdata[$past(op_bit)] == status_flags_register[FLAG_T]
        && ((rf_wdata ^ $past(op_dest_value)) & ~(8'h01 << $past(op_bit))) == 8'h00
        && $stable(status_flags_register))
        else $error("bit load wrong");
    // a back-to-back control op may pulse again in the second cycle
    AST_CTRL: assert property (acc && (op_code == OP_WDOG || op_code == OP_SLEEP) // see RULE6
        |=> ready && op_done && (watchdog_restart || sleep_pulse)
        && $stable(status_flags_register) ##1 ((!watchdog_restart && !sleep_pulse) || $past(acc)))
        else $error("control op wrong");
    AST_LD_RAM: assert property (acc && op_code == OP_LD && op_mode == AM_PLAIN // see RULE7
        && ptr_value < NV_BASE |=> !ready ##1 s_end_write)
        else $error("indirect load count wrong");
    AST_NV_LOAD: assert property (acc && op_code == OP_LD && op_mode == AM_PLAIN // see RULE8
        && ptr_value >= NV_BASE |=> !ready [*2])
        else $error("nonvolatile load too short");
    AST_NV_HOLD: assert property ((state == S_STORE || (state == S_LOAD && acc_nv)) // see RULE9
        && !bus_ack |=> bus_req && !ready && $stable(bus_addr) && $stable(bus_we))
        else $error("stall not held");
    AST_PML: assert property (acc && op_code == OP_PML_R0 |=> pm_req // see RULE10
        && pm_addr == $past(ptr_value) ##1 !ready ##1 (s_end_write and rf_waddr == 5'h00))
        else $error("program load wrong");
    AST_LSR: assert property (acc && op_code == OP_LSR |=> ready // see RULE11
        && rf_wdata[7] == 1'b0
        && status_flags_register[FLAG_C] == $past(op_dest_value[0])
        && status_flags_register[FLAG_T] == $past(status_flags_register[FLAG_T]))
        else $error("shift flags wrong");
endmodule : cmb_exec

// [hw/cmb_exec_dummy_end.sv]
`timescale 1ns/10ps

// [testbench/cmb_mem_model.sv]
`timescale 1ns/10ps
module cmb_mem_model
    import cmb_pkg::*;
(
    // clock
    input wire logic clock,
    // data bus
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_ack,
    // program memory
    input wire logic pm_req,
    input wire logic [15:0] pm_addr,
    output logic [7:0] pm_rdata,
    // grant delay, stands in for contention
    input wire logic [3:0] nv_wait
);
    logic [7:0] mem [0:65535];
    logic [3:0] cnt = 4'h0;
    logic nv;
    assign nv = bus_addr >= NV_BASE;
    // grant held off while contended
    assign bus_ack = bus_req && nv && cnt >= nv_wait;
    // idle bus shows inverted data so stale bytes never match
    assign bus_rdata = bus_req ? mem[bus_addr] : ~mem[bus_addr];
    assign pm_rdata = pm_req ? pm_addr[7:0] ^ 8'h5a : ~(pm_addr[7:0] ^ 8'h5a);
    always @(posedge clock)
    begin
        cnt <= bus_req ? cnt + {3'h0, cnt != 4'hf} : 4'h0;
        if (bus_req && bus_we && (!nv || bus_ack))
        begin
            mem[bus_addr] <= bus_wdata;
        end
    end
endmodule : cmb_mem_model

// [testbench/cpu_data_move_bit_ops_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module cpu_data_move_bit_ops_tb
    import cmb_pkg::*;
;
    logic clock = 1'b0, reset = 1'b1, clock_enable = 1'b1, op_valid = 1'b0;
    cmb_op_t op_code = OP_NOP;
    cmb_mode_t op_mode = AM_PLAIN;
    logic [4:0] op_dest = 5'h00;
    logic [2:0] op_bit = 3'h0;
    logic [15:0] op_addr = 16'h0000, ptr_value = 16'h0000;
    logic [7:0] op_src_value = 8'h00, op_dest_value = 8'h00, io_rdata = 8'h00;
    logic [3:0] nv_wait = 4'h1;
    logic ready, op_done, rf_we, ptr_we, io_we, pm_req, bus_req, bus_we, bus_ack;
    logic break_pulse, sleep_pulse, watchdog_restart;
    logic [4:0] rf_waddr;
    logic [5:0] io_addr;
    logic [7:0] rf_wdata, status_flags_register, bus_wdata, bus_rdata, io_wdata, pm_rdata, f0;
    logic [15:0] ptr_wdata, stack_pointer, bus_addr, pm_addr;
    logic [2:0] side;
    int miscompares = 0, checked = 0, n, n1;
    always #12.5 clock = ~clock;
    cmb_exec uut (.clock, .reset, .clock_enable, .op_valid, .op_code, .op_mode, .op_dest,
        .op_bit, .op_addr, .op_src_value, .op_dest_value, .ptr_value, .io_rdata, .ready,
        .op_done, .rf_we, .rf_waddr, .rf_wdata, .ptr_we, .ptr_wdata, .status_flags_register,
        .stack_pointer, .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack,
        .io_we, .io_addr, .io_wdata, .pm_req, .pm_addr, .pm_rdata, .break_pulse,
        .sleep_pulse, .watchdog_restart);
    cmb_mem_model far (.clock, .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_rdata,
        .bus_ack, .pm_req, .pm_addr, .pm_rdata, .nv_wait);
    // n counts cycles from accept to the done pulse
    task automatic issue(cmb_op_t c, cmb_mode_t m, logic [15:0] a, logic [7:0] s,
        logic [7:0] d, logic [15:0] p);
        @(negedge clock);
        while (ready !== 1'b1) @(negedge clock);
        f0 = status_flags_register;
        {op_code, op_mode, op_addr, op_src_value, op_dest_value, ptr_value} = {c, m, a, s, d, p};
        op_valid = 1'b1;
        @(negedge clock);
        op_valid = 1'b0;
        n = 1;
        while (op_done !== 1'b1 && n < 40) begin @(negedge clock); n++; end
        side = {break_pulse, sleep_pulse, watchdog_restart};
    endtask : issue
    task automatic t_ram;
        far.mem[16'h0123] = 8'ha5;
        op_dest = 5'h07;
        issue(OP_LDDIR, AM_PLAIN, 16'h0123, 8'h00, 8'h00, 16'h0000);
        `CHK("ldir_cycles", 3, n)
        `CHK("ldir_data", 8'ha5, rf_wdata)
        `CHK("ldir_flags", f0, status_flags_register)
        issue(OP_LD, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h0123);
        `CHK("ld_cycles", 2, n)
        issue(OP_STI, AM_POSTINC, 16'h0000, 8'h3c, 8'h00, 16'h0200);
        `CHK("stpost_cycles", 1, n)
        `CHK("stpost_ptr", 16'h0201, ptr_wdata)
        issue(OP_STI, AM_PREDEC, 16'h0000, 8'hc3, 8'h00, 16'h0300);
        `CHK("stpre_cycles", 1, n)
        `CHK("stpre_ptr", 16'h02ff, ptr_wdata)
        @(negedge clock);
        `CHK("stpost_mem", 8'h3c, far.mem[16'h0200])
        `CHK("stpre_mem", 8'hc3, far.mem[16'h02ff])
        issue(OP_STS, AM_PLAIN, 16'h0210, 8'h6b, 8'h00, 16'h0000);
        `CHK("sts_cycles", 2, n)
        issue(OP_LD, AM_DISP, 16'h0010, 8'h00, 8'h00, 16'h0200);
        `CHK("ldd_data", 8'h6b, rf_wdata)
    endtask : t_ram
    task automatic t_stack;
        issue(OP_PUSH, AM_PLAIN, 16'h0000, 8'h5a, 8'h00, 16'h0000);
        `CHK("push_cycles", 1, n)
        `CHK("push_flags", f0, status_flags_register)
        @(negedge clock);
        `CHK("push_mem", 8'h5a, far.mem[16'h0fff])
        `CHK("push_sp", 16'h0ffe, stack_pointer)
        issue(OP_POP, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h0000);
        `CHK("pop_cycles", 2, n)
        `CHK("pop_data", 8'h5a, rf_wdata)
        `CHK("pop_sp", 16'h0fff, stack_pointer)
    endtask : t_stack
    task automatic t_bits;
        op_bit = 3'h6;
        issue(OP_BSET, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h0000);
        `CHK("bset_t", 8'h40, status_flags_register ^ f0)
        op_bit = 3'h3;
        issue(OP_BITLD, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h0000);
        `CHK("bitld_set", 8'h08, rf_wdata)
        `CHK("bitld_flags", f0, status_flags_register)
        `CHK("bitld_cycles", 1, n)
        op_bit = 3'h6;
        issue(OP_BCLR, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h0000);
        op_bit = 3'h0;
        issue(OP_BITLD, AM_PLAIN, 16'h0000, 8'h00, 8'hff, 16'h0000);
        `CHK("bitld_clr", 8'hfe, rf_wdata)
        issue(OP_LSL, AM_PLAIN, 16'h0000, 8'h00, 8'h81, 16'h0000);
        `CHK("lsl_data", 8'h02, rf_wdata)
        `CHK("lsl_carry", 1'b1, status_flags_register[FLAG_C])
        issue(OP_LSR, AM_PLAIN, 16'h0000, 8'h00, 8'h81, 16'h0000);
        `CHK("lsr_data", 8'h40, rf_wdata)
        issue(OP_SWAP, AM_PLAIN, 16'h0000, 8'h00, 8'h3c, 16'h0000);
        `CHK("swap_data", 8'hc3, rf_wdata)
        `CHK("swap_flags", f0, status_flags_register)
        io_rdata = 8'h01;
        op_bit = 3'h3;
        issue(OP_SBI, AM_PLAIN, 16'h0005, 8'h00, 8'h00, 16'h0000);
        `CHK("sbi_io", {1'b1, 6'h05, 8'h09}, {io_we, io_addr, io_wdata})
    endtask : t_bits
    task automatic t_ctrl;
        cmb_op_t ops [4] = '{OP_NOP, OP_BREAK, OP_SLEEP, OP_WDOG};
        logic [2:0] pulse [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
        for (int i = 0; i < 4; i++)
        begin
            issue(ops[i], AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h0000);
            `CHK("ctrl_cycles", 1, n)
            `CHK("ctrl_pulse", pulse[i], side)
            `CHK("ctrl_flags", f0, status_flags_register)
        end
    endtask : t_ctrl
    task automatic t_nv;
        far.mem[16'h4010] = 8'h77;
        issue(OP_LD, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h4010);
        `CHK("nv_ld_slow", 1'b1, n > 2)
        `CHK("nv_ld_data", 8'h77, rf_wdata)
        n1 = n;
        nv_wait = 4'h6;
        issue(OP_LD, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h4010);
        `CHK("nv_ld_stall", 1'b1, n > n1)
        `CHK("nv_ld_data2", 8'h77, rf_wdata)
        issue(OP_STI, AM_PLAIN, 16'h0000, 8'h99, 8'h00, 16'h4020);
        `CHK("nv_st_slow", 1'b1, n > 1)
        @(negedge clock);
        `CHK("nv_st_mem", 8'h99, far.mem[16'h4020])
        nv_wait = 4'h1;
    endtask : t_nv
    task automatic t_pml;
        issue(OP_PML_R0, AM_PLAIN, 16'h0000, 8'h00, 8'h00, 16'h0042);
        `CHK("pml_cycles", 3, n)
        `CHK("pml_reg", 5'h00, rf_waddr)
        `CHK("pml_data", 8'h18, rf_wdata)
        op_dest = 5'h09;
        issue(OP_PML, AM_POSTINC, 16'h0000, 8'h00, 8'h00, 16'h0142);
        `CHK("pmlp_reg", 5'h09, rf_waddr)
        `CHK("pmlp_ptr", 16'h0143, ptr_wdata)
    endtask : t_pml
    task final_report;
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (10) @(posedge clock);
        @(negedge clock) reset = 1'b0;
        t_ram();
        t_stack();
        t_bits();
        t_ctrl();
        t_nv();
        t_pml();
        final_report();
    end
    // whole run is well under a hundred ops
    initial
    begin
        #50000;
        miscompares++;
        final_report();
    end
endmodule : cpu_data_move_bit_ops_tb
